// File: logic/wtb_pkg.sv
package wtb_pkg;
   // geometry of the data memory and the tables
   localparam int unsigned WORD_W     = 16;    // bits per table word
   localparam int unsigned ADDR_W     = 16;    // word address width
   localparam int unsigned LEN_W      = 8;     // table length, 0..ff
   localparam int unsigned BIT_SEL_W  = 4;     // bit within a word
   localparam int unsigned IDX_W      = LEN_W + BIT_SEL_W; // bit index
   localparam int unsigned MEM_DEPTH  = 4096;  // words of data memory
   localparam logic [ADDR_W-1:0] MEM_LAST = 16'h0fff; // top valid address
   localparam logic [WORD_W-1:0] ACC_RESET = 16'h0000; // accumulator reset

   // operation codes presented with a start pulse
   typedef enum logic [1:0] {
      WTB_OP_SET,     // table_bit_set_op
      WTB_OP_CLEAR,   // table_bit_clear_op
      WTB_OP_FILL,
      WTB_OP_FIND
   } wtb_op_t;

   // sequencer states
   typedef enum logic [2:0] {
      WTB_IDLE,
      WTB_BIT_RD,
      WTB_BIT_WR,
      WTB_FILL_WR,
      WTB_FIND_RD,
      WTB_FIND_CMP,
      WTB_DONE
   } wtb_state_t;
endpackage

// File: logic/wtb_mem.sv
`timescale 1ns/1ps
// data memory: one write port, registered read port
module wtb_mem #(
   parameter int unsigned DEPTH = wtb_pkg::MEM_DEPTH
) (
   input  wire logic                        mclk_i,
   input  wire logic                        we_i,
   input  wire logic [wtb_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [wtb_pkg::WORD_W-1:0]  wdata_i,
   output logic      [wtb_pkg::WORD_W-1:0]  rdata_o
);
   // storage array, no reset: contents are software's business
   logic [wtb_pkg::WORD_W-1:0] mem [DEPTH];

   // read one cycle after the address, write in place
   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         mem[addr_i[$clog2(DEPTH)-1:0]] <= wdata_i;
      end
      rdata_o <= mem[addr_i[$clog2(DEPTH)-1:0]];
   end
endmodule

// File: logic/wtb_core.sv
`timescale 1ns/1ps
module wtb_core (
   input  wire logic                        mclk_i,
   input  wire logic                        rst_i,
   input  wire logic                        start_i,      // enable pulse
   input  wire wtb_pkg::wtb_op_t            op_i,
   input  wire logic [wtb_pkg::WORD_W-1:0]  acc_i,        // accumulator
   input  wire logic [wtb_pkg::WORD_W-1:0]  stack1_i,     // stack level 1
   input  wire logic [wtb_pkg::WORD_W-1:0]  stack2_i,     // stack level 2
   input  wire logic [wtb_pkg::WORD_W-1:0]  operand_i,    // bit idx / const
   input  wire logic [wtb_pkg::ADDR_W-1:0]  operand_addr_i, // value address
   input  wire logic                        operand_mem_i,  // 1: fill value from memory
   input  wire logic                        scan_end_i,   // end-of-scan pulse
   output logic                             busy_o,
   output logic                             done_o,       // one-cycle pulse
   output logic      [wtb_pkg::WORD_W-1:0]  acc_o,        // result acc
   output logic                             acc_we_o,     // acc updated
   output logic                             range_error_flag_o
);
   // whole state in one record
   typedef struct packed {
      wtb_pkg::wtb_state_t           st;
      wtb_pkg::wtb_op_t              op;
      logic [wtb_pkg::ADDR_W-1:0]    addr;    // current memory address
      logic [wtb_pkg::LEN_W-1:0]     cnt;     // words left / current offset
      logic [wtb_pkg::LEN_W-1:0]     len;
      logic [wtb_pkg::BIT_SEL_W-1:0] bsel;
      logic [wtb_pkg::WORD_W-1:0]    val;     // fill / search value
      logic                          fetch;   // fill value still to read
      logic                          busy;
      logic                          done;
      logic [wtb_pkg::WORD_W-1:0]    acc;
      logic                          acc_we;
      logic                          err;
   } wtb_core_state_t;

   wtb_core_state_t r;       // registered state
   wtb_core_state_t next_r;  // next state

   logic                       mem_we;
   logic [wtb_pkg::ADDR_W-1:0] mem_addr;
   logic [wtb_pkg::WORD_W-1:0] mem_wdata;
   logic [wtb_pkg::WORD_W-1:0] mem_rdata;

   // true when start + n-1 runs past the top of memory
   function automatic logic past_top(input logic [wtb_pkg::ADDR_W-1:0] s,
                                     input logic [wtb_pkg::LEN_W-1:0] n);
      logic [wtb_pkg::ADDR_W:0] last;
      last = {1'b0, s} + {{(wtb_pkg::ADDR_W-wtb_pkg::LEN_W+1){1'b0}}, n};
      return (n != '0) && (last > {1'b0, wtb_pkg::MEM_LAST} + 17'h00001);
   endfunction

   wtb_mem #(
      .DEPTH(wtb_pkg::MEM_DEPTH)
   ) u_mem (
      .mclk_i  (mclk_i),
      .we_i    (mem_we),
      .addr_i  (mem_addr),
      .wdata_i (mem_wdata),
      .rdata_o (mem_rdata)
   );

   // memory port steering from the current state
   always_comb begin
      mem_we    = 1'b0;
      mem_addr  = r.addr;
      mem_wdata = r.val;
      unique case (r.st)
         wtb_pkg::WTB_IDLE: begin
            // present the fill source early so its word is ready in the
            // first fill cycle; a spare read while idle costs nothing
            if (operand_mem_i) begin
               mem_addr = operand_addr_i;
            end
         end
         wtb_pkg::WTB_BIT_WR: begin
            mem_we = 1'b1;
            // only the addressed bit moves, rest of word kept
            if (r.op == wtb_pkg::WTB_OP_SET) begin
               mem_wdata = mem_rdata | (16'h0001 << r.bsel);
            end else begin
               mem_wdata = mem_rdata & ~(16'h0001 << r.bsel);
            end
         end
         wtb_pkg::WTB_FILL_WR: begin
            mem_we    = !r.fetch && (r.cnt != '0);
            mem_wdata = r.fetch ? mem_rdata : r.val;
         end
         default: begin
         end
      endcase
   end

   // sequencer
   always_comb begin
      logic [wtb_pkg::IDX_W-1:0] idx;
      logic [wtb_pkg::LEN_W-1:0] nxt;
      idx    = operand_i[wtb_pkg::IDX_W-1:0];
      nxt    = '0;
      next_r = r;
      next_r.done   = 1'b0;
      next_r.acc_we = 1'b0;
      // flags only live until the end of the scan
      if (scan_end_i) begin
         next_r.err = 1'b0;
      end
      unique case (r.st)
         wtb_pkg::WTB_IDLE: begin
            // nothing moves unless the rung enables the op
            if (start_i) begin
               next_r.busy = 1'b1;
               next_r.op   = op_i;
               next_r.err  = 1'b0;
               unique case (op_i)
                  wtb_pkg::WTB_OP_SET, wtb_pkg::WTB_OP_CLEAR: begin
                     // length on stack 1, start in acc; index binary, word in 11:4, bit in 3:0
                     next_r.len  = stack1_i[wtb_pkg::LEN_W-1:0];
                     next_r.bsel = idx[wtb_pkg::BIT_SEL_W-1:0];
                     next_r.addr = acc_i + {8'h00, idx[11:4]};
                     // index bits above the field reach past any table
                     if (operand_i[wtb_pkg::WORD_W-1:wtb_pkg::IDX_W] != '0
                         || idx[11:4] >= stack1_i[wtb_pkg::LEN_W-1:0]) begin
                        next_r.err = 1'b1;
                        next_r.st  = wtb_pkg::WTB_DONE;
                     end else begin
                        next_r.st = wtb_pkg::WTB_BIT_RD;
                     end
                  end
                  wtb_pkg::WTB_OP_FILL: begin
                     next_r.cnt   = stack1_i[wtb_pkg::LEN_W-1:0];
                     next_r.fetch = operand_mem_i;
                     next_r.val   = operand_i;
                     next_r.addr  = operand_mem_i ? operand_addr_i : acc_i;
                     if (past_top(acc_i, stack1_i[wtb_pkg::LEN_W-1:0])) begin
                        next_r.err = 1'b1;
                        next_r.st  = wtb_pkg::WTB_DONE;
                     end else begin
                        next_r.st = wtb_pkg::WTB_FILL_WR;
                     end
                  end
                  default: begin // find
                     next_r.len  = stack2_i[wtb_pkg::LEN_W-1:0];
                     next_r.cnt  = acc_i[wtb_pkg::LEN_W-1:0];
                     next_r.val  = operand_i;
                     next_r.addr = stack1_i + acc_i;
                     // offset must land inside the table
                     if (acc_i >= {8'h00, stack2_i[wtb_pkg::LEN_W-1:0]}) begin
                        next_r.err    = 1'b1;
                        next_r.acc    = wtb_pkg::ACC_RESET;
                        next_r.acc_we = 1'b1;
                        next_r.st     = wtb_pkg::WTB_DONE;
                     end else begin
                        next_r.st = wtb_pkg::WTB_FIND_RD;
                     end
                  end
               endcase
            end
         end
         wtb_pkg::WTB_BIT_RD: begin
            next_r.st = wtb_pkg::WTB_BIT_WR; // read data lands next cycle
         end
         wtb_pkg::WTB_BIT_WR: begin
            next_r.st = wtb_pkg::WTB_DONE;
         end
         wtb_pkg::WTB_FILL_WR: begin
            if (r.fetch) begin
               // one idle cycle to pick up the referenced word
               next_r.fetch = 1'b0;
               next_r.val   = mem_rdata;
               next_r.addr  = acc_i;
            end else if (r.cnt == '0) begin
               next_r.st = wtb_pkg::WTB_DONE;
            end else begin
               next_r.cnt  = r.cnt - 8'h01;
               next_r.addr = r.addr + 16'h0001;
            end
         end
         wtb_pkg::WTB_FIND_RD: begin
            next_r.st = wtb_pkg::WTB_FIND_CMP;
         end
         wtb_pkg::WTB_FIND_CMP: begin
            nxt = r.cnt + 8'h01;
            if (mem_rdata == r.val) begin
               // first hit wins, offset from table start
               next_r.acc    = {8'h00, r.cnt};
               next_r.acc_we = 1'b1;
               next_r.st     = wtb_pkg::WTB_DONE;
            end else if ({1'b0, nxt} >= {1'b0, r.len} || nxt == '0) begin
               next_r.acc    = wtb_pkg::ACC_RESET;
               next_r.acc_we = 1'b1;
               next_r.err    = 1'b1;
               next_r.st     = wtb_pkg::WTB_DONE;
            end else begin
               next_r.cnt  = nxt;
               next_r.addr = r.addr + 16'h0001;
               next_r.st   = wtb_pkg::WTB_FIND_RD;
            end
         end
         wtb_pkg::WTB_DONE: begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
            next_r.st   = wtb_pkg::WTB_IDLE;
         end
         default: begin
            next_r.st = wtb_pkg::WTB_IDLE;
         end
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r        <= '0;
         r.st     <= wtb_pkg::WTB_IDLE;
         r.acc    <= wtb_pkg::ACC_RESET;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state flops
   assign busy_o             = r.busy;
   assign done_o             = r.done;
   assign acc_o              = r.acc;
   assign acc_we_o           = r.acc_we;
   assign range_error_flag_o = r.err;
endmodule

// File: tb/wtb_prog.sv
`timescale 1ns/1ps
// controller side: stacks the operands of each table op
module wtb_prog (
   input  wire logic             req_i,     // scan reaches the op
   input  wire wtb_pkg::wtb_op_t op_i,
   input  wire logic [15:0]      base_i,    // table start
   input  wire logic [7:0]       len_i,     // table length
   input  wire logic [15:0]      off_i,     // search start offset
   output logic                  start_o,
   output logic      [15:0]      acc_o,
   output logic      [15:0]      stack1_o,
   output logic      [15:0]      stack2_o
);
   wire find = op_i == wtb_pkg::WTB_OP_FIND;
   assign start_o = req_i;
   // bit ops, fill: length on level 1, start in acc
   assign acc_o = find ? off_i : base_i;
   assign stack1_o = find ? base_i : {8'h00, len_i};
   // level 2 is stale for non-find ops, so never a tidy zero
   assign stack2_o = find ? {8'h00, len_i} : ~{8'h00, len_i};
endmodule

// File: tb/wtb_core_sva.sv
`timescale 1ns/1ps
// watches the core ports only
module wtb_core_sva (
   input wire logic             mclk_i,
   input wire logic             rst_i,
   input wire logic             start_i,
   input wire wtb_pkg::wtb_op_t op_i,
   input wire logic [15:0]      acc_i,
   input wire logic [15:0]      stack1_i,
   input wire logic [15:0]      stack2_i,
   input wire logic [15:0]      operand_i,
   input wire logic             scan_end_i,
   input wire logic             busy_o,
   input wire logic             done_o,
   input wire logic [15:0]      acc_o,
   input wire logic             acc_we_o,
   input wire logic             range_error_flag_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // accepted request and its range checks
   wire take = start_i && !busy_o;
   wire bit_op = op_i == wtb_pkg::WTB_OP_SET || op_i == wtb_pkg::WTB_OP_CLEAR;
   wire bit_bad = operand_i >= {4'h0, stack1_i[7:0], 4'h0};
   wire off_bad = acc_i >= {8'h00, stack2_i[7:0]};
   // fill whose last word would land above the top of memory
   wire fill_bad = op_i == wtb_pkg::WTB_OP_FILL && stack1_i[7:0] != 8'h00
      && {1'b0, acc_i} + {9'h000, stack1_i[7:0]}
         > {1'b0, wtb_pkg::MEM_LAST} + 17'h00001;
   // requests refused at once, flag raised on the taking edge
   wire early_bad = (bit_op && bit_bad) || fill_bad
      || (op_i == wtb_pkg::WTB_OP_FIND && off_bad);
   sequence s_err_done;
      done_o && range_error_flag_o;
   endsequence
   sequence s_ok_done;
      done_o && !range_error_flag_o;
   endsequence
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   a_start_clears: assert property (take && !early_bad
      |=> !range_error_flag_o) else $error("error flag kept over a new op");
   a_scan_clears: assert property (scan_end_i && !take && !busy_o
      |=> !range_error_flag_o) else $error("scan end left error flag");
   a_bit_outside: assert property (take && bit_op && bit_bad
      |-> ##2 s_err_done) else $error("bad bit index not refused");
   a_bit_inside: assert property (take && bit_op && !bit_bad
      |-> ##4 s_ok_done) else $error("bit op timing or flag wrong");
   a_find_offset: assert property (take && op_i == wtb_pkg::WTB_OP_FIND
      && off_bad |-> ##2 s_err_done)
      else $error("bad search offset not flagged");
   a_fill_outside: assert property (take && fill_bad
      |-> ##2 s_err_done) else $error("fill past memory top not flagged");
   a_acc_only_we: assert property ($changed(acc_o) |-> acc_we_o)
      else $error("acc changed without write");
   a_acc_then_done: assert property (acc_we_o |=> done_o)
      else $error("acc write not followed by done");
   a_done_idle: assert property (done_o |-> !busy_o)
      else $error("busy while done");
endmodule
bind wtb_core wtb_core_sva wtb_core_sva_i (.mclk_i(mclk_i), .rst_i(rst_i),
   .start_i(start_i), .op_i(op_i), .acc_i(acc_i), .stack1_i(stack1_i),
   .stack2_i(stack2_i), .operand_i(operand_i), .scan_end_i(scan_end_i),
   .busy_o(busy_o), .done_o(done_o), .acc_o(acc_o), .acc_we_o(acc_we_o),
   .range_error_flag_o(range_error_flag_o));

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic mclk_i = 1'b0, rst_i = 1'b1, req = 1'b0, scan_end = 1'b0;
   logic vmem = 1'b0;
   wtb_pkg::wtb_op_t op = wtb_pkg::WTB_OP_FILL;
   logic [15:0] base = 16'h0000, off = 16'h0000, val = 16'h0000;
   logic [15:0] vaddr = 16'h0000, acc, st1, st2, acc_res, pat;
   logic [7:0] len = 8'h00;
   logic [11:0] idx;
   logic start, busy, done, acc_we, err;
   logic exp_err[$];            // flag expected at each done
   logic [15:0] exp_acc[$];     // acc expected at each write
   int n_mismatch = 0, comparisons = 0, cycles = 0, i;
   logic [31:0] rng = 32'h7137;
   always #4 mclk_i = ~mclk_i;
   wtb_prog wtb_prog_i (.req_i(req), .op_i(op), .base_i(base), .len_i(len),
      .off_i(off), .start_o(start), .acc_o(acc), .stack1_o(st1),
      .stack2_o(st2));
   wtb_core wtb_core_i (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start),
      .op_i(op), .acc_i(acc), .stack1_i(st1), .stack2_i(st2),
      .operand_i(val), .operand_addr_i(vaddr), .operand_mem_i(vmem),
      .scan_end_i(scan_end), .busy_o(busy), .done_o(done), .acc_o(acc_res),
      .acc_we_o(acc_we), .range_error_flag_o(err));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic give_verdict();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp_err(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t flag %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_acc(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t acc %h exp %h", $time, g, e);
      end
   endtask
   // one op: note expectations, pulse request, wait for done
   task automatic run(input wtb_pkg::wtb_op_t o, input logic [15:0] b,
         input logic [7:0] l, input logic [15:0] f, v, input logic m,
         input logic e, input logic [15:0] r);
      int k;
      op = o;
      base = b;
      len = l;
      off = f;
      val = v;
      vmem = m;
      vaddr = 16'h0202;        // only read when m is set; holds ffdf
      req = 1'b1;
      exp_err.push_back(e);
      if (o == wtb_pkg::WTB_OP_FIND) exp_acc.push_back(r);
      @(posedge mclk_i) #1 req = 1'b0;
      for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge mclk_i) #1;
      if (done !== 1'b1) n_mismatch++; // limit ran out, no answer
   endtask
   // result watcher, sampled mid-cycle
   always @(negedge mclk_i) begin
      if (acc_we === 1'b1 && exp_acc.size() > 0)
         cmp_acc(acc_res, exp_acc.pop_front());
      if (done === 1'b1 && exp_err.size() > 0)
         cmp_err(err, exp_err.pop_front());
   end
   // hang guard
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      for (i = 0; i < 4; i++) begin
         rng = xs(rng);
         idx = {5'h00, rng[6:0]};
         pat = 16'h0001 << idx[3:0];
         run(wtb_pkg::WTB_OP_FILL, 16'h0100, 8'h08, 0, 0, 0, 0, 0);
         run(wtb_pkg::WTB_OP_SET, 16'h0100, 8'h08, 0, {4'h0, idx}, 0, 0, 0);
         run(wtb_pkg::WTB_OP_FIND, 16'h0100, 8'h08, 0, pat, 0, 0,
            {13'h0000, idx[6:4]});
         run(wtb_pkg::WTB_OP_CLEAR, 16'h0100, 8'h08, 0, {4'h0, idx}, 0, 0, 0);
         run(wtb_pkg::WTB_OP_FIND, 16'h0100, 8'h08, 0, pat, 0, 1, 0);
      end
      run(wtb_pkg::WTB_OP_SET, 16'h0100, 8'h08, 0, 16'h0080, 0, 1, 0);
      run(wtb_pkg::WTB_OP_FILL, 16'h0200, 8'h04, 0, 16'hffff, 0, 0, 0);
      run(wtb_pkg::WTB_OP_CLEAR, 16'h0200, 8'h04, 0, 16'h0025, 0, 0, 0);
      run(wtb_pkg::WTB_OP_FIND, 16'h0200, 8'h04, 0, 16'hffdf, 0, 0,
         16'h0002);
      run(wtb_pkg::WTB_OP_FIND, 16'h0200, 8'h04, 3, 16'hffff, 0, 0,
         16'h0003);
      run(wtb_pkg::WTB_OP_FILL, 16'h0300, 8'h03, 0, 0, 1, 0, 0);
      run(wtb_pkg::WTB_OP_FIND, 16'h0300, 8'h03, 2, 16'hffdf, 0, 0,
         16'h0002);
      run(wtb_pkg::WTB_OP_FIND, 16'h0300, 8'h03, 3, 16'hffff, 0, 1, 0);
      run(wtb_pkg::WTB_OP_FILL, wtb_pkg::MEM_LAST, 8'h02, 0, 0, 0, 1, 0);
      scan_end = 1'b1;
      @(posedge mclk_i) #1 scan_end = 1'b0;
      cmp_err(err, 1'b0);
      // a note never matched to a result means a lost answer
      if (exp_err.size() != 0 || exp_acc.size() != 0) n_mismatch++;
      give_verdict();
   end
endmodule
